// ===== rtl/apclm_regs.svh
`ifndef APCLM_REGS_SVH
`define APCLM_REGS_SVH

// Register byte offsets
`define APCLM_CLKCHK_OFS      8'h00
`define APCLM_STATUS_OFS      8'h04
`define APCLM_INTMASK_OFS     8'h08
`define APCLM_LOOPBACK_OFS    8'h0c
`define APCLM_GLOBAL_OFS      8'h10
`define APCLM_SLOTS_OFS       8'h14
`define APCLM_TXCLK_OFS       8'h18
`define APCLM_PINFUNC_OFS     8'h1c
`define APCLM_PINDIR_OFS      8'h20

// Clock check control fields
`define APCLM_MIN_LSB         0
`define APCLM_MAX_LSB         16
`define APCLM_CNT_LSB         24
// Status and mask bit
`define APCLM_FAIL_BIT        0
// Loopback control fields
`define APCLM_LB_EN_BIT       0
`define APCLM_LB_ORD_BIT      1
`define APCLM_LB_MODE_LSB     2
// Global control bits
`define APCLM_G_RXHF_BIT      0
`define APCLM_G_RXRUN_BIT     1
`define APCLM_G_TXRUN_BIT     2
// Slot count fields
`define APCLM_TXSLOT_LSB      0
`define APCLM_RXSLOT_LSB      16
// Transmit clock control tx_rx_select_a select bit
`define APCLM_TX_RX_SELECT_A_BIT       6

// Reset values
`define APCLM_MIN_RST         8'h00
`define APCLM_MAX_RST         8'hff
`define APCLM_MASK_RST        1'b0
`define APCLM_TX_RX_SELECT_A_RST       1'b1
`define APCLM_SLOT_RST        9'h000

// Counts and limits
`define APCLM_WINDOW_EDGES    6'h20
`define APCLM_TDM_MIN_SLOTS   9'h002
`define APCLM_TDM_MAX_SLOTS   9'h020
`define APCLM_LB_MODE_TXCLK   2'b01

`endif

// ===== rtl/apclm_pkg.sv
package apclm_pkg;

    // Number of serializers handled by the router
    localparam int APCLM_NSER = 4;

    // Clock source selection of the receive section
    typedef enum logic [1:0] {
        apclm_rxclk_own,
        apclm_rxclk_from_tx
    } apclm_rxclk_t;

    typedef logic [7:0] apclm_count_t;
    typedef logic [8:0] apclm_slots_t;

endpackage

// ===== rtl/apclm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "apclm_regs.svh"

module apclm_top
    import apclm_pkg::*;
(
    // System clock and resets
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psc_reset_n,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Interrupt
    output logic                       irq,
    // Clock pins from the converters
    input  wire logic                  rx_hf_clock,
    input  wire logic                  tx_bclk_pin,
    input  wire logic                  tx_fs_pin,
    input  wire logic                  rx_bclk_pin,
    input  wire logic                  rx_fs_pin,
    // Serializer side
    input  wire logic [APCLM_NSER-1:0] ser_tx_data,
    output logic      [APCLM_NSER-1:0] ser_rx_data,
    output logic                       rx_bclk_used,
    output logic                       rx_fs_used,
    output logic                       rx_section_run,
    output logic                       tx_section_run,
    // Serial data pins
    input  wire logic [APCLM_NSER-1:0] ser_pin_in,
    output logic      [APCLM_NSER-1:0] ser_pin_out,
    output logic      [APCLM_NSER-1:0] ser_pin_oe
);

    // Combined asynchronous reset
    wire logic rst_n;
    assign rst_n = presetn & psc_reset_n;

    // Software registers
    apclm_count_t              rx_count_min_limit;
    apclm_count_t              rx_count_max_limit;
    apclm_count_t              rx_window_count;
    logic                      rx_clock_fail_flag;
    logic                      fail_mask;
    logic                      loopback_enable;
    logic                      loopback_order;
    logic [1:0]                loopback_mode;
    logic [2:0]                global_control_reg;
    apclm_slots_t              tx_slot_count_field;
    apclm_slots_t              rx_slot_count_field;
    logic                      tx_rx_select_a;
    logic [APCLM_NSER-1:0]     pin_function_select;
    logic [APCLM_NSER-1:0]     pin_direction_select;

    // Synchronisers for pins and the monitored clock
    logic [1:0]                hf_sync;
    logic                      hf_prev;
    logic [1:0]                txb_sync;
    logic [1:0]                txf_sync;
    logic [1:0]                rxb_sync;
    logic [1:0]                rxf_sync;
    logic                      rxb_prev;
    logic                      txb_prev;
    logic [APCLM_NSER-1:0]     pin_s1;
    logic [APCLM_NSER-1:0]     pin_s2;

    // Monitor state
    apclm_count_t              live_count;
    logic [5:0]                edge_count;

    // APB decode
    wire logic                 apb_access;
    wire logic                 apb_done;
    wire logic                 apb_wr;
    wire logic                 hit_clkchk;
    wire logic                 hit_status;
    wire logic                 hit_mask;
    wire logic                 hit_loop;
    wire logic                 hit_global;
    wire logic                 hit_slots;
    wire logic                 hit_txclk;
    wire logic                 hit_func;
    wire logic                 hit_dir;
    wire logic                 hit_any;
    logic      [31:0]          read_mux;

    assign apb_access = psel & penable;
    assign apb_done   = apb_access & pready;
    assign apb_wr     = apb_done & pwrite;
    assign hit_clkchk = (paddr == `APCLM_CLKCHK_OFS);
    assign hit_status = (paddr == `APCLM_STATUS_OFS);
    assign hit_mask   = (paddr == `APCLM_INTMASK_OFS);
    assign hit_loop   = (paddr == `APCLM_LOOPBACK_OFS);
    assign hit_global = (paddr == `APCLM_GLOBAL_OFS);
    assign hit_slots  = (paddr == `APCLM_SLOTS_OFS);
    assign hit_txclk  = (paddr == `APCLM_TXCLK_OFS);
    assign hit_func   = (paddr == `APCLM_PINFUNC_OFS);
    assign hit_dir    = (paddr == `APCLM_PINDIR_OFS);
    assign hit_any    = hit_clkchk | hit_status | hit_mask | hit_loop | hit_global
                      | hit_slots | hit_txclk | hit_func | hit_dir;

    // Read data selection, stored count is read-only
    always_comb begin
        read_mux = 32'h0000_0000;
        if (hit_clkchk) begin
            read_mux[`APCLM_MIN_LSB +: 8] = rx_count_min_limit;
            read_mux[`APCLM_MAX_LSB +: 8] = rx_count_max_limit;
            read_mux[`APCLM_CNT_LSB +: 8] = rx_window_count;
        end else if (hit_status) begin
            read_mux[`APCLM_FAIL_BIT] = rx_clock_fail_flag;
        end else if (hit_mask) begin
            read_mux[`APCLM_FAIL_BIT] = fail_mask;
        end else if (hit_loop) begin
            read_mux[`APCLM_LB_EN_BIT]        = loopback_enable;
            read_mux[`APCLM_LB_ORD_BIT]       = loopback_order;
            read_mux[`APCLM_LB_MODE_LSB +: 2] = loopback_mode;
        end else if (hit_global) begin
            read_mux[2:0] = global_control_reg;
        end else if (hit_slots) begin
            read_mux[`APCLM_TXSLOT_LSB +: 9] = tx_slot_count_field;
            read_mux[`APCLM_RXSLOT_LSB +: 9] = rx_slot_count_field;
        end else if (hit_txclk) begin
            read_mux[`APCLM_TX_RX_SELECT_A_BIT] = tx_rx_select_a;
        end else if (hit_func) begin
            read_mux[APCLM_NSER-1:0] = pin_function_select;
        end else if (hit_dir) begin
            read_mux[APCLM_NSER-1:0] = pin_direction_select;
        end
    end

    // APB answer, one wait state per access
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_access & ~pready;
            prdata  <= (apb_access & ~pready & ~pwrite) ? read_mux : 32'h0000_0000;
            pslverr <= apb_access & ~pready & ~hit_any;
        end
    end

    // Writable control registers
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_count_min_limit   <= `APCLM_MIN_RST;
            rx_count_max_limit   <= `APCLM_MAX_RST;
            fail_mask            <= `APCLM_MASK_RST;
            loopback_enable      <= 1'b0;
            loopback_order       <= 1'b0;
            loopback_mode        <= 2'b00;
            global_control_reg   <= 3'h0;
            tx_slot_count_field  <= `APCLM_SLOT_RST;
            rx_slot_count_field  <= `APCLM_SLOT_RST;
            tx_rx_select_a       <= `APCLM_TX_RX_SELECT_A_RST;
            pin_function_select  <= {APCLM_NSER{1'b1}};
            pin_direction_select <= {APCLM_NSER{1'b0}};
        end else if (apb_wr) begin
            if (hit_clkchk) begin
                rx_count_min_limit <= pwdata[`APCLM_MIN_LSB +: 8];
                rx_count_max_limit <= pwdata[`APCLM_MAX_LSB +: 8];
            end else if (hit_mask) begin
                fail_mask <= pwdata[`APCLM_FAIL_BIT];
            end else if (hit_loop) begin
                loopback_enable <= pwdata[`APCLM_LB_EN_BIT];
                loopback_order  <= pwdata[`APCLM_LB_ORD_BIT];
                loopback_mode   <= pwdata[`APCLM_LB_MODE_LSB +: 2];
            end else if (hit_global) begin
                global_control_reg <= pwdata[2:0];
            end else if (hit_slots) begin
                tx_slot_count_field <= pwdata[`APCLM_TXSLOT_LSB +: 9];
                rx_slot_count_field <= pwdata[`APCLM_RXSLOT_LSB +: 9];
            end else if (hit_txclk) begin
                tx_rx_select_a <= pwdata[`APCLM_TX_RX_SELECT_A_BIT];
            end else if (hit_func) begin
                pin_function_select <= pwdata[APCLM_NSER-1:0];
            end else if (hit_dir) begin
                pin_direction_select <= pwdata[APCLM_NSER-1:0];
            end
        end
    end

    // Two-flop synchronisers, second stage feeds logic
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            hf_sync  <= 2'b00;
            txb_sync <= 2'b00;
            txf_sync <= 2'b00;
            rxb_sync <= 2'b00;
            rxf_sync <= 2'b00;
            pin_s1   <= {APCLM_NSER{1'b0}};
            pin_s2   <= {APCLM_NSER{1'b0}};
        end else begin
            hf_sync  <= {hf_sync[0], rx_hf_clock};
            txb_sync <= {txb_sync[0], tx_bclk_pin};
            txf_sync <= {txf_sync[0], tx_fs_pin};
            rxb_sync <= {rxb_sync[0], rx_bclk_pin};
            rxf_sync <= {rxf_sync[0], rx_fs_pin};
            pin_s1   <= ser_pin_in;
            pin_s2   <= pin_s1;
        end
    end

    // Clock monitor decode
    wire logic  hf_rise;
    wire logic  monitor_on;
    wire logic  window_end;
    wire logic  min_fail;
    wire logic  max_fail;
    wire logic  fail_event;
    wire logic  fail_clear;
    assign hf_rise    = hf_sync[1] & ~hf_prev;
    assign monitor_on = global_control_reg[`APCLM_G_RXHF_BIT];
    assign window_end = monitor_on & hf_rise & (edge_count == (`APCLM_WINDOW_EDGES - 6'h01));
    assign min_fail   = window_end & (live_count < rx_count_min_limit);
    assign max_fail   = monitor_on & (live_count > rx_count_max_limit);
    assign fail_event = min_fail | max_fail;
    assign fail_clear = apb_wr & hit_status & pwdata[`APCLM_FAIL_BIT];

    // Window counters, live count saturates
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            hf_prev         <= 1'b0;
            edge_count      <= 6'h00;
            live_count      <= 8'h00;
            rx_window_count <= 8'h00;
        end else begin
            hf_prev <= hf_sync[1];
            if (!monitor_on) begin
                edge_count <= 6'h00;
                live_count <= 8'h00;
            end else if (window_end) begin
                edge_count      <= 6'h00;
                live_count      <= 8'h01;
                rx_window_count <= live_count;
            end else begin
                if (hf_rise) begin
                    edge_count <= edge_count + 6'h01;
                end
                if (live_count != 8'hff) begin
                    live_count <= live_count + 8'h01;
                end
            end
        end
    end

    // Sticky failure flag, set wins over clear
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_clock_fail_flag <= 1'b0;
        end else if (fail_event) begin
            rx_clock_fail_flag <= 1'b1;
        end else if (fail_clear) begin
            rx_clock_fail_flag <= 1'b0;
        end
    end

    // Interrupt output
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= rx_clock_fail_flag & fail_mask;
        end
    end

    // Loopback qualification
    wire logic        tx_tdm;
    wire logic        rx_tdm;
    wire logic        lb_active;
    wire apclm_rxclk_t rx_clk_src;
    assign tx_tdm     = (tx_slot_count_field >= `APCLM_TDM_MIN_SLOTS)
                      & (tx_slot_count_field <= `APCLM_TDM_MAX_SLOTS);
    assign rx_tdm     = (rx_slot_count_field >= `APCLM_TDM_MIN_SLOTS)
                      & (rx_slot_count_field <= `APCLM_TDM_MAX_SLOTS);
    assign lb_active  = loopback_enable & tx_tdm & rx_tdm;
    assign rx_clk_src = (lb_active && loopback_mode == `APCLM_LB_MODE_TXCLK)
                      ? apclm_rxclk_from_tx : apclm_rxclk_own;

    // Serializer routing per lane
    logic [APCLM_NSER-1:0] next_rx_data;
    genvar gi;
    generate
        for (gi = 0; gi < APCLM_NSER; gi = gi + 1) begin : g_lane
            wire logic looped;
            if (gi % 2 == 0) begin : g_even
                if (gi + 1 < APCLM_NSER) begin : g_pair
                    assign looped = loopback_order ? 1'b0 : ser_tx_data[gi+1];
                end else begin : g_last
                    assign looped = 1'b0;
                end
            end else begin : g_odd
                assign looped = loopback_order ? ser_tx_data[gi-1] : 1'b0;
            end
            assign next_rx_data[gi] = lb_active ? looped : pin_s2[gi];
        end
    endgenerate

    // Serializer and pin outputs
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            ser_rx_data <= {APCLM_NSER{1'b0}};
            ser_pin_out <= {APCLM_NSER{1'b0}};
            ser_pin_oe  <= {APCLM_NSER{1'b0}};
        end else begin
            ser_rx_data <= next_rx_data;
            ser_pin_out <= ser_tx_data;
            ser_pin_oe  <= ~pin_function_select & pin_direction_select;
        end
    end

    // Receive clock and frame sync selection
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_bclk_used <= 1'b0;
            rx_fs_used   <= 1'b0;
        end else begin
            rx_bclk_used <= (rx_clk_src == apclm_rxclk_from_tx) ? txb_sync[1] : rxb_sync[1];
            rx_fs_used   <= (rx_clk_src == apclm_rxclk_from_tx) ? txf_sync[1] : rxf_sync[1];
        end
    end

    // Section run bits follow only on serial clock edges
    wire logic rx_bclk_rise;
    wire logic tx_bclk_rise;
    assign rx_bclk_rise = rx_bclk_used & ~rxb_prev;
    assign tx_bclk_rise = txb_sync[1] & ~txb_prev;
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            rxb_prev       <= 1'b0;
            txb_prev       <= 1'b0;
            rx_section_run <= 1'b0;
            tx_section_run <= 1'b0;
        end else begin
            rxb_prev <= rx_bclk_used;
            txb_prev <= txb_sync[1];
            if (rx_bclk_rise) begin
                rx_section_run <= global_control_reg[`APCLM_G_RXRUN_BIT];
            end
            if (tx_bclk_rise) begin
                tx_section_run <= global_control_reg[`APCLM_G_TXRUN_BIT];
            end
        end
    end

endmodule // apclm_top

`default_nettype wire

// ===== verification/apclm_props.sv
`timescale 1ns/1ps
`default_nettype none

module apclm_props
    import apclm_pkg::*;
(
    // Clock and resets
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psc_reset_n,
    // Bus and interrupt
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [31:0]           prdata,
    input wire logic                  irq,
    // Pins and serializers
    input wire logic                  tx_bclk_pin,
    input wire logic                  tx_section_run,
    input wire logic [APCLM_NSER-1:0] ser_tx_data,
    input wire logic [APCLM_NSER-1:0] ser_pin_out,
    input wire logic [APCLM_NSER-1:0] ser_pin_oe
);
    logic rst_free;

    // Both resets released
    assign rst_free = presetn && psc_reset_n;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!rst_free);

    // Bus answer timing
    AST_ONE_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("bus answer not after one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_REFUSED_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access returned data");
    // Pin path
    AST_PIN_COPY: assert property ($past(rst_free) |-> ser_pin_out == $past(ser_tx_data))
        else $error("pin data not a copy of transmit data");
    AST_OE_HOLD: assert property (!pready && !$past(pready) && !$past(pready, 2) |=> $stable(ser_pin_oe))
        else $error("pin enable moved without a write");
    // Failure interrupt, resets and transmit run bit
    AST_IRQ_STICKY: assert property (irq && !$past(pready) |=> irq)
        else $error("interrupt dropped without a write");
    AST_PSC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        !psc_reset_n |-> !irq && !pready && ser_pin_oe == '0)
        else $error("module reset left outputs active");
    AST_TX_RUN: assert property ($stable(tx_bclk_pin) [*8] |=> $stable(tx_section_run))
        else $error("transmit run changed without a bit clock");

    COV_IRQ: cover property ($rose(irq));
    COV_REFUSED: cover property (pslverr);
    COV_TX_RUN: cover property ($rose(tx_section_run));
endmodule // apclm_props

bind apclm_top apclm_props u_props (.pclk(pclk), .presetn(presetn), .psc_reset_n(psc_reset_n), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq(irq),
    .tx_bclk_pin(tx_bclk_pin), .tx_section_run(tx_section_run), .ser_tx_data(ser_tx_data),
    .ser_pin_out(ser_pin_out), .ser_pin_oe(ser_pin_oe));

`default_nettype wire

// ===== verification/apclm_conv_model.sv
`timescale 1ns/1ps
`default_nettype none

module apclm_conv_model
    import apclm_pkg::*;
(
    // Controls from the bench
    input  wire logic                  hf_run,
    input  wire logic                  hf_fast,
    input  wire logic                  bclk_run,
    // Data pins of the block
    input  wire logic [APCLM_NSER-1:0] ser_pin_out,
    input  wire logic [APCLM_NSER-1:0] ser_pin_oe,
    // Clocks and data towards the block
    output logic                       rx_hf_clock,
    output logic                       tx_bclk_pin,
    output logic                       rx_bclk_pin,
    output logic                       tx_fs_pin,
    output logic                       rx_fs_pin,
    output logic      [APCLM_NSER-1:0] ser_pin_in
);
    logic [3:0] noise;
    logic [3:0] bit_cnt;

    // Monitored clock, 125 ns or fast, still when stopped
    initial begin
        rx_hf_clock = 1'b0;
        forever begin
            if (hf_run) #(hf_fast ? 12.5 : 62.5) rx_hf_clock = ~rx_hf_clock;
            else #0.7;
        end
    end

    // Bit clocks run only while bclk_run is set, idle high and low
    initial begin
        bit_cnt = 4'h0;
        forever begin
            if (bclk_run) begin
                #62.5;
                {tx_bclk_pin, rx_bclk_pin} = ~{tx_bclk_pin, rx_bclk_pin};
                bit_cnt = bit_cnt + 4'h1;
            end else begin
                {tx_bclk_pin, rx_bclk_pin} = 2'b10;
                #0.9;
            end
        end
    end
    assign tx_fs_pin = bit_cnt[3];
    assign rx_fs_pin = bit_cnt[3];

    // Undriven data pins wander
    initial begin
        noise = 4'h0;
        forever #3.3 noise = noise + 4'h5;
    end
    assign ser_pin_in = (ser_pin_oe & ser_pin_out) | (~ser_pin_oe & noise);
endmodule // apclm_conv_model

`default_nettype wire

// ===== verification/apclm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module apclm_tb_top
    import apclm_pkg::*;
;
    logic                  pclk, presetn, psc_reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic                  hf_clk, tx_bclk, tx_fs, rx_bclk, rx_fs, hf_run, hf_fast, bclk_run;
    logic                  bclk_used, fs_used, rx_run, tx_run, act;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, last_rd;
    logic [APCLM_NSER-1:0] tx_data, rx_data, pin_in, pin_out, pin_oe, tx, lb_exp;
    logic [32:0]           exp_q[$], msk_q[$];
    logic [8:0]            lb_slots[9] = '{9'h004, 9'h004, 9'h020, 9'h002, 9'h004, 9'h001, 9'h021, 9'h180, 9'h000};
    logic [3:0]            lb_ctrl[9] = '{4'h5, 4'h7, 4'h7, 4'h1, 4'h4, 4'h5, 4'h7, 4'h5, 4'h5};
    int                    bad_count, comparisons, seed;

    apclm_top DUT (.pclk(pclk), .presetn(presetn), .psc_reset_n(psc_reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .rx_hf_clock(hf_clk), .tx_bclk_pin(tx_bclk), .tx_fs_pin(tx_fs), .rx_bclk_pin(rx_bclk),
        .rx_fs_pin(rx_fs), .ser_tx_data(tx_data), .ser_rx_data(rx_data), .rx_bclk_used(bclk_used),
        .rx_fs_used(fs_used), .rx_section_run(rx_run), .tx_section_run(tx_run), .ser_pin_in(pin_in),
        .ser_pin_out(pin_out), .ser_pin_oe(pin_oe));
    apclm_conv_model u_conv (.hf_run(hf_run), .hf_fast(hf_fast), .bclk_run(bclk_run), .ser_pin_out(pin_out),
        .ser_pin_oe(pin_oe), .rx_hf_clock(hf_clk), .tx_bclk_pin(tx_bclk), .rx_bclk_pin(rx_bclk),
        .tx_fs_pin(tx_fs), .rx_fs_pin(rx_fs), .ser_pin_in(pin_in));

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One bus transfer, expected {error, data} noted for the monitor
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                       input logic [32:0] m = {33{1'b1}});
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; the wait ends when pready is high, or at the hang guard
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Reset values, refused address, read-only count
    task automatic defaults();
        logic [7:0]  ofs[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
        logic [31:0] val[9] = '{32'h00ff0000, 0, 0, 0, 0, 0, 32'h40, 32'hf, 0};
        for (int i = 0; i < 9; i++) apb(1'b0, ofs[i], 32'h0, {1'b0, val[i]});
        apb(1'b1, 8'h24, 32'h1, 33'h1_0000_0000);
        apb(1'b0, 8'h24, 32'h0, 33'h1_0000_0000);
        apb(1'b1, 8'h00, 32'haaff0000, 33'h0);
        apb(1'b0, 8'h00, 32'h0, 33'h0_00ff_0000);
    endtask

    // Answers compared with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            last_rd = prdata;
            check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
        end
    end

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Hang guard
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        seed = 54;
        {presetn, psc_reset_n, psel, penable, pwrite, hf_run, hf_fast, bclk_run} = 8'h40;
        {paddr, pwdata, tx_data} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        defaults();
        // Stopped link clock overruns the maximum
        apb(1'b1, 8'h00, 32'h0010_0000, 33'h0);
        apb(1'b1, 8'h10, 32'h1, 33'h0);
        repeat (40) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0, 33'h1);
        apb(1'b1, 8'h08, 32'h1, 33'h0);
        repeat (3) @(posedge pclk);
        check(33'(irq), 33'h1);
        apb(1'b1, 8'h08, 32'h0, 33'h0);
        repeat (3) @(posedge pclk);
        check(33'(irq), 33'h0);
        apb(1'b1, 8'h10, 32'h0, 33'h0);
        apb(1'b1, 8'h04, 32'h1, 33'h0);
        apb(1'b0, 8'h04, 32'h0, 33'h0);
        // Nominal link clock, count saturates
        apb(1'b1, 8'h00, 32'h00ff_0000, 33'h0);
        hf_run <= 1'b1;
        apb(1'b1, 8'h10, 32'h1, 33'h0);
        repeat (2500) @(posedge pclk);
        apb(1'b1, 8'h04, 32'h1, 33'h0);
        repeat (1100) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0, 33'h0);
        apb(1'b0, 8'h00, 32'h0, 33'h0_ffff_0000);
        // Fast link clock against minimum limits
        hf_fast <= 1'b1;
        apb(1'b1, 8'h00, 32'h00ff_00ff, 33'h0);
        repeat (600) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0, 33'h1);
        apb(1'b0, 8'h00, 32'h0, 33'h0_00ff_00ff, 33'h1_00ff_ffff);
        check(33'(last_rd[31:24] inside {[8'hc5:8'hcb]}), 33'h1);
        apb(1'b1, 8'h00, 32'h00ff_0040, 33'h0);
        repeat (450) @(posedge pclk);
        apb(1'b1, 8'h04, 32'h1, 33'h0);
        repeat (450) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0, 33'h0);
        hf_run <= 1'b0;
        psc_reset_n <= 1'b0;
        repeat (2) @(posedge pclk);
        psc_reset_n <= 1'b1;
        @(posedge pclk);
        defaults();
        // Loopback routing over slot counts, orders and modes
        apb(1'b1, 8'h1c, 32'h0, 33'h0);
        apb(1'b1, 8'h20, 32'hf, 33'h0);
        apb(1'b1, 8'h18, 32'h0, 33'h0);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 8'h14, {7'h0, lb_slots[i], 7'h0, lb_slots[i]}, 33'h0);
            apb(1'b1, 8'h0c, {28'h0, lb_ctrl[i]}, 33'h0);
            tx = 4'($random(seed)) | (i[0] ? 4'h5 : 4'ha);
            tx_data <= tx;
            repeat (8) @(posedge pclk);
            act = lb_ctrl[i][0] && lb_slots[i] >= 9'h002 && lb_slots[i] <= 9'h020;
            lb_exp = !act ? tx : lb_ctrl[i][1] ? {tx[2], 1'b0, tx[0], 1'b0} : {1'b0, tx[3], 1'b0, tx[1]};
            check(33'(pin_out), 33'(tx));
            check(33'(pin_oe), 33'hf);
            check(33'(fs_used), 33'h0);
            check(33'(rx_data), 33'(lb_exp));
            if (act) check(33'(bclk_used), 33'(lb_ctrl[i][3:2] == 2'b01));
        end
        // Section run bits wait for their bit clocks
        apb(1'b1, 8'h10, 32'h7, 33'h0);
        repeat (20) @(posedge pclk);
        check(33'({rx_run, tx_run}), 33'h0);
        bclk_run <= 1'b1;
        repeat (100) @(posedge pclk);
        check(33'({rx_run, tx_run}), 33'h3);
        report_and_stop();
    end
endmodule // apclm_tb_top

`default_nettype wire
